// ---- rtl/hcd_pkg.sv ----
// constants, field layouts and carrier types for the host command decoder
// Contract
// - low-byte general settings apply with every command and are saved on flash save
// - general bit 6 freezes the 8.16 line frequency value; clearing resumes updates
// - general bit 5 selects line-cycle locked or fixed-sample accumulation
// - general bit 4 enables temperature based gain compensation
// - zero in bits 23:12 does nothing; bit 10 then holds the temperature result
// - code 0xACC with 0x2 saves coefficients and defaults to flash
// - flash save stores general bits and zero upper sixteen bits
// - after flash save or clear, bits 23:8 clear, general bits stay
// - code 0xACC with 0x0 or 0x1 erases stored flash coefficients
// - code 0xCA in bits 23:16 starts calibration of selected inputs
// - bits 14,13,12,11 pick sensors two, zero, three, one; bit 15 zero
// - calibration bit 9 selects offset instead of gain calibration
// - calibration bit 10 chip temperature, bit 8 external temperature gain
// - calibration end clears code byte and passed bits, failed bits stay
// - code 0xBD with bits 11:0 zero performs a soft reset
// - clear control bit 2 accumulators and frame, 1 counters, 0 min/max
// - config bits 23:22 pick frequency reference: s0, s2, s0-s2, s0+s2
// - config bits 19:0 hold two-bit weights for voltages and currents
// - weight code 00 is -1, 01 is 0, 10 is 1, 11 is 2
// - command register is readable so the host can poll completion
package hcd_pkg;

  localparam int DATA_W = 24;
  localparam int ADDR_W = 8;

  // word addresses
  localparam logic [7:0] ADDR_HOST_TASK_REQUEST = 8'h00;
  localparam logic [7:0] ADDR_MEASUREMENT_CLEAR_CTRL = 8'h24;
  localparam logic [7:0] ADDR_INPUT_SOURCE_SELECT = 8'h25;

  // reset values
  localparam logic [23:0] RST_HOST_TASK_REQUEST = 24'h000000;
  localparam logic [23:0] RST_MEASUREMENT_CLEAR_CTRL = 24'h000000;
  localparam logic [23:0] RST_INPUT_SOURCE_SELECT = 24'h000000;

  // command codes
  localparam logic [11:0] CODE_NO_ACTION = 12'h000;
  localparam logic [11:0] CODE_ACCESS = 12'hacc;
  localparam logic [3:0] SUB_CLEAR0 = 4'h0;
  localparam logic [3:0] SUB_CLEAR1 = 4'h1;
  localparam logic [3:0] SUB_SAVE = 4'h2;
  localparam logic [7:0] CODE_CALIBRATE = 8'hca;
  localparam logic [7:0] CODE_SOFT_RESET = 8'hbd;
  localparam logic [15:0] SAVED_UPPER = 16'h0000;

  // general settings bits
  localparam int BIT_LINE_RATE_HOLD = 6;
  localparam int BIT_CYCLE_LOCKED_ACCUM = 5;
  localparam int BIT_THERMAL_GAIN_COMP = 4;
  localparam int BIT_TEMP_HOLD = 10;

  // calibration bits
  localparam int BIT_CAL_S2 = 14;
  localparam int BIT_CAL_S0 = 13;
  localparam int BIT_CAL_S3 = 12;
  localparam int BIT_CAL_S1 = 11;
  localparam int BIT_CAL_CHIP_TEMP = 10;
  localparam int BIT_CAL_OFFSET = 9;
  localparam int BIT_CAL_REMOTE_TEMP = 8;

  // clear control bits
  localparam int BIT_CLR_ACCUM_FRAME = 2;
  localparam int BIT_CLR_COUNTERS = 1;
  localparam int BIT_CLR_MINMAX = 0;

  // config reference field
  localparam int REF_SEL_LSB = 22;

  // calibration request carrier
  typedef struct packed {
    logic [3:0] volt_sel;      // index = sensor number
    logic chip_temp;
    logic offset_mode;
    logic remote_thermal_cal;
  } hcd_cal_req_t;

  // decoded signed weights, value range -1..2
  typedef struct packed {
    logic signed [2:0] aux_w2;
    logic signed [2:0] aux_w0;
    logic signed [2:0] line_volt_b_w2;
    logic signed [2:0] line_volt_b_w0;
    logic signed [2:0] line_volt_a_w2;
    logic signed [2:0] line_volt_a_w0;
    logic signed [2:0] load_cur_b_w3;
    logic signed [2:0] load_cur_b_w1;
    logic signed [2:0] load_cur_a_w3;
    logic signed [2:0] load_cur_a_w1;
  } hcd_weights_t;

  // reference choices
  typedef enum logic [1:0] {
    REF_SENSOR_ZERO,
    REF_SENSOR_TWO,
    REF_ZERO_MINUS_TWO,
    REF_ZERO_PLUS_TWO
  } hcd_ref_t;

endpackage

// ---- rtl/hcd_host_command_decoder.sv ----
// host command decoder: command, clear control and input config registers
`timescale 1ns/1ps
module hcd_host_command_decoder
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // word register port from the serial interface
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [23:0] reg_wdata_in,
  output logic [23:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // general settings
  output logic line_rate_hold_out,
  output logic cycle_locked_accum_out,
  output logic thermal_gain_comp_out,
  output logic die_heat_result_hold_out,
  // flash storage
  output logic flash_save_out,
  output logic flash_clear_out,
  output logic flash_bank_out,
  output logic [23:0] flash_word_out,
  input wire logic flash_done_in,
  // calibration
  output logic cal_start_out,
  output hcd_pkg::hcd_cal_req_t cal_req_out,
  input wire logic cal_done_in,
  input wire logic [6:0] cal_fail_in,
  // soft reset
  output logic soft_reset_out,
  // measurement clears
  output logic clr_accum_frame_out,
  output logic clr_counters_out,
  output logic clr_minmax_out,
  // input configuration
  output hcd_pkg::hcd_ref_t ref_sel_out,
  output hcd_pkg::hcd_weights_t weights_out
);

  typedef enum logic [1:0] {
    HCD_IDLE,
    HCD_FLASH_BUSY,
    HCD_CAL_BUSY
  } hcd_state_t;

  hcd_state_t state;
  logic [23:0] host_task_request;
  logic [23:0] measurement_clear_ctrl;
  logic [23:0] input_source_select;

  logic wr_cmd;
  logic wr_clr;
  logic wr_cfg;
  logic is_no_action;
  logic is_access;
  logic is_save;
  logic is_clear;
  logic is_cal;
  logic is_soft_reset;
  default clocking hcd_cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  // decoded two-bit weight: code minus one
  function automatic logic signed [2:0] weight_of(input logic [1:0] code);
    weight_of = $signed({1'b0, code}) - 3'sd1;
  endfunction

  assign wr_cmd = reg_wr_in && (reg_addr_in == hcd_pkg::ADDR_HOST_TASK_REQUEST)
    && (state == HCD_IDLE);
  assign wr_clr = reg_wr_in && (reg_addr_in == hcd_pkg::ADDR_MEASUREMENT_CLEAR_CTRL);
  assign wr_cfg = reg_wr_in && (reg_addr_in == hcd_pkg::ADDR_INPUT_SOURCE_SELECT);

  assign is_no_action = reg_wdata_in[23:12] == hcd_pkg::CODE_NO_ACTION;
  assign is_access = reg_wdata_in[23:12] == hcd_pkg::CODE_ACCESS;
  assign is_save = is_access && (reg_wdata_in[11:8] == hcd_pkg::SUB_SAVE);
  assign is_clear = is_access && ((reg_wdata_in[11:8] == hcd_pkg::SUB_CLEAR0)
    || (reg_wdata_in[11:8] == hcd_pkg::SUB_CLEAR1));
  assign is_cal = reg_wdata_in[23:16] == hcd_pkg::CODE_CALIBRATE;
  // soft reset needs zero low field
  assign is_soft_reset = (reg_wdata_in[23:16] == hcd_pkg::CODE_SOFT_RESET)
    && (reg_wdata_in[11:0] == 12'h000);

  // sequencer for flash and calibration jobs
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state <= HCD_IDLE;
    end
    else
    begin
      case (state)
        HCD_IDLE:
        begin
          if (wr_cmd && (is_save || is_clear))
          begin
            state <= HCD_FLASH_BUSY;
          end
          else if (wr_cmd && is_cal)
          begin
            state <= HCD_CAL_BUSY;
          end
        end
        HCD_FLASH_BUSY:
        begin
          if (flash_done_in)
          begin
            state <= HCD_IDLE;
          end
        end
        HCD_CAL_BUSY:
        begin
          if (cal_done_in)
          begin
            state <= HCD_IDLE;
          end
        end
        default:
        begin
          state <= HCD_IDLE;
        end
      endcase
    end
  end

  // command register storage and completion clearing
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      host_task_request <= hcd_pkg::RST_HOST_TASK_REQUEST;
    end
    else if (wr_cmd)
    begin
      host_task_request <= reg_wdata_in;
    end
    else if ((state == HCD_FLASH_BUSY) && flash_done_in)
    begin
      host_task_request[23:8] <= 16'h0000;
    end
    else if ((state == HCD_CAL_BUSY) && cal_done_in)
    begin
      host_task_request[23:16] <= 8'h00;
      host_task_request[14:8] <= host_task_request[14:8] & cal_fail_in;
    end
  end
  a_flash_done_clear: assert property (
    ((state == HCD_FLASH_BUSY) && flash_done_in) |=> (host_task_request[23:8] == 16'h0000)
    && $stable(host_task_request[7:0]))
    else $error("flash completion did not clear command bits 23:8");
  a_cal_fail_keep: assert property (
    ((state == HCD_CAL_BUSY) && cal_done_in) |=> (host_task_request[23:16] == 8'h00)
    && (state == HCD_IDLE)
    && (host_task_request[14:8] == ($past(host_task_request[14:8]) & $past(cal_fail_in))))
    else $error("calibration completion left wrong bits");

  // general settings follow every accepted command word
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      line_rate_hold_out <= 1'b0;
      cycle_locked_accum_out <= 1'b0;
      thermal_gain_comp_out <= 1'b0;
    end
    else if (wr_cmd)
    begin
      line_rate_hold_out <= reg_wdata_in[hcd_pkg::BIT_LINE_RATE_HOLD];
      cycle_locked_accum_out <= reg_wdata_in[hcd_pkg::BIT_CYCLE_LOCKED_ACCUM];
      thermal_gain_comp_out <= reg_wdata_in[hcd_pkg::BIT_THERMAL_GAIN_COMP];
    end
  end

  // temperature result hold, changed only by no-action words
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      die_heat_result_hold_out <= 1'b0;
    end
    else if (wr_cmd && is_no_action)
    begin
      die_heat_result_hold_out <= reg_wdata_in[hcd_pkg::BIT_TEMP_HOLD];
    end
  end
  a_temp_hold_keep: assert property (
    (wr_cmd && !is_no_action) |=> $stable(die_heat_result_hold_out))
    else $error("temperature hold changed by a non no-action word");

  // flash requests
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      flash_save_out <= 1'b0;
      flash_clear_out <= 1'b0;
      flash_bank_out <= 1'b0;
      flash_word_out <= 24'h000000;
    end
    else
    begin
      flash_save_out <= wr_cmd && is_save;
      flash_clear_out <= wr_cmd && is_clear;
      if (wr_cmd && (is_save || is_clear))
      begin
        flash_bank_out <= reg_wdata_in[8];
        flash_word_out <= {hcd_pkg::SAVED_UPPER, reg_wdata_in[7:0]};
      end
    end
  end
  a_save_pulse_once: assert property (
    (wr_cmd && is_save) |=> (flash_save_out && (state == HCD_FLASH_BUSY)) ##1 !flash_save_out)
    else $error("save command did not raise one save pulse");
  a_save_word_form: assert property (
    flash_save_out |-> (flash_word_out == {hcd_pkg::SAVED_UPPER, host_task_request[7:0]}))
    else $error("saved word is not general bits with zero upper part");
  a_clear_flash_cmd: assert property (
    (wr_cmd && is_access && (reg_wdata_in[11:9] == 3'h0)) |=>
    flash_clear_out && (flash_bank_out == $past(reg_wdata_in[8])))
    else $error("clear flash command not requested");

  // calibration request
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cal_start_out <= 1'b0;
      cal_req_out <= '0;
    end
    else
    begin
      cal_start_out <= wr_cmd && is_cal;
      if (wr_cmd && is_cal)
      begin
        cal_req_out.volt_sel <= {reg_wdata_in[hcd_pkg::BIT_CAL_S3],
          reg_wdata_in[hcd_pkg::BIT_CAL_S2], reg_wdata_in[hcd_pkg::BIT_CAL_S1],
          reg_wdata_in[hcd_pkg::BIT_CAL_S0]};
        cal_req_out.chip_temp <= reg_wdata_in[hcd_pkg::BIT_CAL_CHIP_TEMP];
        cal_req_out.remote_thermal_cal <= reg_wdata_in[hcd_pkg::BIT_CAL_REMOTE_TEMP];
        cal_req_out.offset_mode <= reg_wdata_in[hcd_pkg::BIT_CAL_OFFSET];
      end
    end
  end
  a_cal_select_map: assert property (
    (wr_cmd && is_cal) |=> cal_start_out && (cal_req_out.volt_sel == {$past(reg_wdata_in[12]),
    $past(reg_wdata_in[14]), $past(reg_wdata_in[11]), $past(reg_wdata_in[13])}))
    else $error("calibration sensor selection mismatch");

  // soft reset pulse
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      soft_reset_out <= 1'b0;
    end
    else
    begin
      soft_reset_out <= wr_cmd && is_soft_reset;
    end
  end
  a_soft_reset_pulse: assert property (
    soft_reset_out |-> ($past(reg_wdata_in[23:16]) == hcd_pkg::CODE_SOFT_RESET)
    && ($past(reg_wdata_in[11:0]) == 12'h000) && $past(wr_cmd))
    else $error("soft reset without its command word");

  // clear control register and its clear pulses
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      measurement_clear_ctrl <= hcd_pkg::RST_MEASUREMENT_CLEAR_CTRL;
      clr_accum_frame_out <= 1'b0;
      clr_counters_out <= 1'b0;
      clr_minmax_out <= 1'b0;
    end
    else
    begin
      clr_accum_frame_out <= wr_clr && reg_wdata_in[hcd_pkg::BIT_CLR_ACCUM_FRAME];
      clr_counters_out <= wr_clr && reg_wdata_in[hcd_pkg::BIT_CLR_COUNTERS];
      clr_minmax_out <= wr_clr && reg_wdata_in[hcd_pkg::BIT_CLR_MINMAX];
      if (wr_clr)
      begin
        measurement_clear_ctrl <= {21'h000000, reg_wdata_in[2:0]};
      end
    end
  end
  a_clear_pulse: assert property (
    clr_counters_out == $past(wr_clr && reg_wdata_in[hcd_pkg::BIT_CLR_COUNTERS]))
    else $error("counter clear pulse does not follow its write");

  // input configuration register and decoded fields
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      input_source_select <= hcd_pkg::RST_INPUT_SOURCE_SELECT;
      ref_sel_out <= hcd_pkg::REF_SENSOR_ZERO;
      weights_out <= '0;
    end
    else if (wr_cfg)
    begin
      input_source_select <= reg_wdata_in;
      ref_sel_out <= hcd_pkg::hcd_ref_t'(reg_wdata_in[hcd_pkg::REF_SEL_LSB +: 2]);
      weights_out.aux_w2 <= weight_of(reg_wdata_in[19:18]);
      weights_out.aux_w0 <= weight_of(reg_wdata_in[17:16]);
      weights_out.line_volt_b_w2 <= weight_of(reg_wdata_in[15:14]);
      weights_out.line_volt_b_w0 <= weight_of(reg_wdata_in[13:12]);
      weights_out.line_volt_a_w2 <= weight_of(reg_wdata_in[11:10]);
      weights_out.line_volt_a_w0 <= weight_of(reg_wdata_in[9:8]);
      weights_out.load_cur_b_w3 <= weight_of(reg_wdata_in[7:6]);
      weights_out.load_cur_b_w1 <= weight_of(reg_wdata_in[5:4]);
      weights_out.load_cur_a_w3 <= weight_of(reg_wdata_in[3:2]);
      weights_out.load_cur_a_w1 <= weight_of(reg_wdata_in[1:0]);
    end
  end
  a_weight_decode: assert property (
    (wr_cfg && (reg_wdata_in[1:0] == 2'b00)) |=> (weights_out.load_cur_a_w1 == -3'sd1))
    else $error("weight code 00 not decoded as minus one");

  // read port, one cycle latency, unmapped words read zero
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reg_rdata_out <= 24'h000000;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          hcd_pkg::ADDR_HOST_TASK_REQUEST: reg_rdata_out <= host_task_request;
          hcd_pkg::ADDR_MEASUREMENT_CLEAR_CTRL: reg_rdata_out <= measurement_clear_ctrl;
          hcd_pkg::ADDR_INPUT_SOURCE_SELECT: reg_rdata_out <= input_source_select;
          default: reg_rdata_out <= 24'h000000;
        endcase
      end
    end
  end

endmodule

// ---- tb/hcd_job_engine.sv ----
// flash and calibration job engine model answering the decoder's job requests
`timescale 1ns/1ps
module hcd_job_engine
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // job requests from the decoder
  input wire logic flash_save_in,
  input wire logic flash_clear_in,
  input wire logic cal_start_in,
  // behaviour set by the bench
  input wire logic [7:0] delay_in,
  input wire logic [6:0] fail_in,
  // job completion
  output logic flash_done_out,
  output logic cal_done_out,
  output logic [6:0] cal_fail_out
);
  logic [7:0] cnt;
  logic busy;
  logic is_cal;
  logic [6:0] last_fail;

  // one job at a time; fail mask only meaningful with the done pulse
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt <= 8'h00;
      busy <= 1'b0;
      is_cal <= 1'b0;
      last_fail <= 7'h00;
      flash_done_out <= 1'b0;
      cal_done_out <= 1'b0;
      cal_fail_out <= 7'h00;
    end
    else
    begin
      flash_done_out <= 1'b0;
      cal_done_out <= 1'b0;
      cal_fail_out <= ~last_fail;
      if (flash_save_in || flash_clear_in || cal_start_in)
      begin
        busy <= 1'b1;
        is_cal <= cal_start_in;
        cnt <= delay_in;
      end
      else if (busy && cnt == 8'h00)
      begin
        busy <= 1'b0;
        flash_done_out <= !is_cal;
        cal_done_out <= is_cal;
        if (is_cal)
        begin
          cal_fail_out <= fail_in;
          last_fail <= fail_in;
        end
      end
      else if (busy)
      begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// ---- tb/tb_host_command_decoder.sv ----
// self-checking testbench for the host command decoder
`timescale 1ns/1ps
module tb_host_command_decoder;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [23:0] reg_wdata_in = 24'h000000;
  logic [23:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic line_rate_hold_out, cycle_locked_accum_out, thermal_gain_comp_out;
  logic die_heat_result_hold_out, flash_save_out, flash_clear_out, flash_bank_out;
  logic [23:0] flash_word_out;
  logic flash_done_in, cal_start_out, cal_done_in, soft_reset_out;
  hcd_pkg::hcd_cal_req_t cal_req_out;
  logic [6:0] cal_fail_in;
  logic clr_accum_frame_out, clr_counters_out, clr_minmax_out;
  hcd_pkg::hcd_ref_t ref_sel_out;
  hcd_pkg::hcd_weights_t weights_out;
  logic [7:0] delay = 8'd20;
  logic [6:0] fail = 7'h00;
  logic [23:0] v;
  int n_errors = 0;
  int comparisons = 0;

  hcd_host_command_decoder i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .line_rate_hold_out(line_rate_hold_out),
    .cycle_locked_accum_out(cycle_locked_accum_out),
    .thermal_gain_comp_out(thermal_gain_comp_out),
    .die_heat_result_hold_out(die_heat_result_hold_out), .flash_save_out(flash_save_out),
    .flash_clear_out(flash_clear_out), .flash_bank_out(flash_bank_out),
    .flash_word_out(flash_word_out), .flash_done_in(flash_done_in),
    .cal_start_out(cal_start_out), .cal_req_out(cal_req_out), .cal_done_in(cal_done_in),
    .cal_fail_in(cal_fail_in), .soft_reset_out(soft_reset_out),
    .clr_accum_frame_out(clr_accum_frame_out), .clr_counters_out(clr_counters_out),
    .clr_minmax_out(clr_minmax_out), .ref_sel_out(ref_sel_out), .weights_out(weights_out));

  hcd_job_engine i_engine (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .flash_save_in(flash_save_out), .flash_clear_in(flash_clear_out),
    .cal_start_in(cal_start_out), .delay_in(delay), .fail_in(fail),
    .flash_done_out(flash_done_in), .cal_done_out(cal_done_in), .cal_fail_out(cal_fail_in));

  initial
  begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one word write; effect outputs are settled when this returns
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_sys_in);
    #1 reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge clk_sys_in);
    #1 reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk_sys_in);
    #1 reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(posedge clk_sys_in);
    #1 reg_rd_in = 1'b0;
    chk("rvalid", {31'h0, reg_rvalid_out}, 32'h1);
    d = reg_rdata_out;
  endtask

  // poll the command register until the masked bits are clear
  task automatic wait_done(input logic [23:0] mask, input logic [23:0] exp);
    logic [23:0] r;
    int i;
    r = mask;
    for (i = 0; i < 100 && (r & mask) != 24'h0; i++)
      rd(hcd_pkg::ADDR_HOST_TASK_REQUEST, r);
    chk("command after job", {8'h0, r}, {8'h0, exp});
  endtask

  task automatic cal(input logic [23:0] w, input logic [6:0] f, input logic [6:0] req,
                     input logic [23:0] exp);
    fail = f;
    wr(hcd_pkg::ADDR_HOST_TASK_REQUEST, w);
    chk("cal_start", {31'h0, cal_start_out}, 32'h1);
    chk("cal_req", {25'h0, cal_req_out}, {25'h0, req});
    wait_done(24'hff0000, exp);
  endtask

  initial
  begin
    #100000;
    n_errors++;
    summarize();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    #1 reset_n_in = 1'b1;
    rd(hcd_pkg::ADDR_HOST_TASK_REQUEST, v);
    chk("command reset", {8'h0, v}, 32'h0);
    rd(hcd_pkg::ADDR_INPUT_SOURCE_SELECT, v);
    chk("config reset", {8'h0, v}, 32'h0);
    rd(8'h01, v);
    chk("unmapped read", {8'h0, v}, 32'h0);
    $display("test reset done");
    // settings with no-action word; reserved bits 3:0 set too
    wr(hcd_pkg::ADDR_HOST_TASK_REQUEST, 24'h00047f);
    chk("settings", {28'h0, line_rate_hold_out, cycle_locked_accum_out,
        thermal_gain_comp_out, die_heat_result_hold_out}, 32'hf);
    rd(hcd_pkg::ADDR_HOST_TASK_REQUEST, v);
    chk("command readback", {8'h0, v}, 32'h00047f);
    wr(hcd_pkg::ADDR_HOST_TASK_REQUEST, 24'h000000);
    chk("settings off", {28'h0, line_rate_hold_out, cycle_locked_accum_out,
        thermal_gain_comp_out, die_heat_result_hold_out}, 32'h0);
    $display("test settings done");
    wr(hcd_pkg::ADDR_HOST_TASK_REQUEST, 24'hacc245);
    chk("save pulse", {30'h0, flash_save_out, flash_bank_out}, 32'h2);
    chk("save word", {8'h0, flash_word_out}, 32'h000045);
    chk("save settings", {31'h0, line_rate_hold_out}, 32'h1);
    // a command written while the job runs is dropped
    wr(hcd_pkg::ADDR_HOST_TASK_REQUEST, 24'h000000);
    wait_done(24'hffff00, 24'h000045);
    chk("hold kept", {31'h0, line_rate_hold_out}, 32'h1);
    $display("test flash save done");
    // host clears the two storages one after the other
    // paired clears
    for (int b = 0; b < 2; b++)
    begin
      wr(hcd_pkg::ADDR_HOST_TASK_REQUEST, {12'hacc, 4'(b), 8'h11});
      chk("clear pulse", {30'h0, flash_clear_out, flash_bank_out}, {30'h0, 1'b1, 1'(b)});
      wait_done(24'hffff00, 24'h000011);
    end
    $display("test flash clear done");
    cal(24'hca6000, 7'b1000000, 7'b0101000, 24'h004000);
    cal(24'hca0710, 7'b0000000, 7'b0000111, 24'h000010);
    chk("cal settings", {30'h0, thermal_gain_comp_out, die_heat_result_hold_out},
        32'h2);
    $display("test calibration done");
    wr(hcd_pkg::ADDR_HOST_TASK_REQUEST, 24'hbd0000);
    chk("soft reset", {31'h0, soft_reset_out}, 32'h1);
    $display("test soft reset done");
    for (int i = 0; i < 3; i++)
    begin
      wr(hcd_pkg::ADDR_MEASUREMENT_CLEAR_CTRL, 24'(1 << i));
      chk("clear pulses", {29'h0, clr_accum_frame_out, clr_counters_out, clr_minmax_out},
          32'(1 << i));
    end
    rd(hcd_pkg::ADDR_MEASUREMENT_CLEAR_CTRL, v);
    chk("clear readback", {8'h0, v}, 32'h000004);
    $display("test clear ctrl done");
    for (int r = 0; r < 4; r++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        wr(hcd_pkg::ADDR_INPUT_SOURCE_SELECT, {2'(r), 2'b00, {10{2'(c)}}});
        chk("ref sel", {30'h0, ref_sel_out}, 32'(r));
        chk("weights", {2'h0, weights_out}, {2'h0, {10{3'(c) - 3'd1}}});
      end
    end
    wr(hcd_pkg::ADDR_INPUT_SOURCE_SELECT, 24'h000001);
    chk("weight order", {2'h0, weights_out}, {2'h0, {9{3'b111}}, 3'b000});
    rd(hcd_pkg::ADDR_INPUT_SOURCE_SELECT, v);
    chk("config readback", {8'h0, v}, 32'h000001);
    $display("test config done");
    summarize();
  end
endmodule
